// [rtl/socket_power_pkg.sv]
// Constants for the per-socket power control register bank.
// Assumes a single 100 MHz clock and the register access port of socket_power_ctrl.
// Function
// R1 - Bit 7 gates all 16-bit card outputs
// R2 - Legacy layout: bit 6 reads zero
// R3 - Legacy bit 5 enables card-detect power switching
// R4 - Legacy bit 4 enables supply, level external
// R5 - Legacy layout: bits 3,2 read zero
// R6 - Legacy Vpp field: 00 off, 10 12V, 01 Vcc
// R7 - Legacy: Vpp ignored while supply disabled
// R8 - Extended: bits 6,5,2 read zero, unwritable
// R9 - Extended Vcc field: 10 5V, 11 3.3V
// R10 - Extended Vpp ignored unless supply is on
// R11 - Bus reset spares marked bits when wake enabled
// R12 - One copy per socket, offsets 02h/42h/802h
// R13 - Revision resets 0100b; 0010b selects legacy
// R14 - Power status shows supply and Vpp on; code shows supply on alone
// R15 - Legacy reserved bits drop written data
package socket_power_pkg;
    // Register offsets
    localparam logic [7:0] OFS_POWER_IDX = 8'h02;
    localparam logic [7:0] OFS_REV_IDX = 8'h00;
    localparam logic [7:0] SOCK_STRIDE = 8'h40;
    localparam logic [11:0] OFS_POWER_REL = 12'h802;
    localparam logic [11:0] OFS_REV_REL = 12'h800;
    // Field positions
    localparam int BIT_GATE = 7;
    localparam int BIT_AUTO = 5;
    localparam int BIT_SUPPLY_EN = 4;
    localparam int VCC_LSB = 3;
    localparam int VPP_LSB = 0;
    // Field encodings
    localparam logic [1:0] VPP_12V = 2'h2;
    localparam logic [1:0] VPP_VCC = 2'h1;
    localparam logic [1:0] VCC_5V = 2'h2;
    localparam logic [1:0] VCC_3V3 = 2'h3;
    // Writable and reset-surviving bit masks per layout
    localparam logic [7:0] MASK_LEGACY = 8'hb3;
    localparam logic [7:0] MASK_EXT = 8'h9b;
    localparam logic [7:0] KEEP_LEGACY = 8'h20;
    localparam logic [7:0] KEEP_EXT = 8'h9b;
    localparam logic [7:0] POWER_RESET = 8'h00;
    // Compatibility revision values and the read value of unmapped offsets
    localparam logic [3:0] REV_RESET = 4'h4;
    localparam logic [3:0] REV_LEGACY = 4'h2;
    localparam logic [7:0] READ_NONE = 8'h00;
endpackage

// [rtl/socket_power_reg.sv]
// One socket's power control register with its output decode.
// Assumes bus reset, wake enable and card detect already synchronised by the parent.
`timescale 1ns/1ns
`default_nettype none
module socket_power_reg
    import socket_power_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic rst_b, // Global reset, async, low
    input wire logic wrEn, // Write strobe for this copy
    input wire logic [7:0] wrData, // Write data
    input wire logic legacyMode, // Legacy register layout selected
    input wire logic busReset, // Synchronised bus reset, high
    input wire logic pmeEnable, // Synchronised power-event wake enable
    input wire logic cardIn, // Card detected, synchronised
    input wire logic supplySelect, // Legacy supply level: 1 = 3.3 V
    output logic [7:0] readValue, // Masked register read value
    output logic cardOutputsGate, // 16-bit outputs enabled
    output logic autoPowerSwitchEnable, // Auto switching active
    output logic supplyEn5, // Card supply at 5 V
    output logic supplyEn33, // Card supply at 3.3 V
    output logic vpp12En, // Vpp at 12 V
    output logic vppVccEn, // Vpp tied to card supply
    output logic socketPowerStatus // Card supply turned on
);
    logic [7:0] store_q, store_d;
    logic [6:0] outs_q, outs_d;
    logic [7:0] layMask;
    logic [7:0] keepMask;
    logic supplyOn;
    logic level33;
    logic [1:0] vccField;
    logic [1:0] vppField;

    // Next register value; bus reset has priority over a write in the same cycle
    always_comb
    begin
        layMask = legacyMode ? MASK_LEGACY : MASK_EXT;
        keepMask = pmeEnable ? (legacyMode ? KEEP_LEGACY : KEEP_EXT) : POWER_RESET;
        store_d = store_q;
        if (busReset)
        begin
            store_d = store_q & keepMask; // R11
        end
        else if (wrEn)
        begin
            store_d = (store_q & ~layMask) | (wrData & layMask); // R8 R15
        end
    end

    // Output decode from the stored value
    always_comb
    begin
        vccField = store_q[VCC_LSB +: 2];
        vppField = store_q[VPP_LSB +: 2];
        if (legacyMode)
        begin
            // Auto switching withholds supply from an empty socket
            supplyOn = store_q[BIT_SUPPLY_EN] && (!store_q[BIT_AUTO] || cardIn); // R3 R4
            level33 = supplySelect; // R4
        end
        else
        begin
            supplyOn = (vccField == VCC_5V) || (vccField == VCC_3V3); // R9
            level33 = (vccField == VCC_3V3); // R9
        end
        outs_d[0] = store_q[BIT_GATE]; // R1
        outs_d[1] = legacyMode && store_q[BIT_AUTO]; // R3
        outs_d[2] = supplyOn && !level33;
        outs_d[3] = supplyOn && level33;
        outs_d[4] = supplyOn && (vppField == VPP_12V); // R6 R7 R10
        outs_d[5] = supplyOn && (vppField == VPP_VCC); // R6 R7 R10
        outs_d[6] = supplyOn; // R14
    end

    // State registers; the global reset clears everything
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            store_q <= POWER_RESET;
            outs_q <= 7'h00;
        end
        else
        begin
            store_q <= store_d;
            outs_q <= outs_d;
        end
    end

    // Reserved bits always read zero in either layout
    assign readValue = store_q & (legacyMode ? MASK_LEGACY : MASK_EXT); // R2 R5 R8
    assign cardOutputsGate = outs_q[0];
    assign autoPowerSwitchEnable = outs_q[1];
    assign supplyEn5 = outs_q[2];
    assign supplyEn33 = outs_q[3];
    assign vpp12En = outs_q[4];
    assign vppVccEn = outs_q[5];
    assign socketPowerStatus = outs_q[6];

    property p_gate;
        @(posedge clk_sys) disable iff (!rst_b)
        (wrEn && !busReset) |=> ##1 (cardOutputsGate == $past(wrData[BIT_GATE], 2));
    endproperty
    a_gate: assert property (p_gate) else $error("Output gate does not follow bit 7"); // R1

    property p_legacy_rsvd;
        @(posedge clk_sys) disable iff (!rst_b)
        legacyMode |-> (readValue[6] == 1'b0 && readValue[3:2] == 2'b00);
    endproperty
    a_legacy_rsvd: assert property (p_legacy_rsvd) else $error("Legacy reserved bit reads one"); // R2 R5 R15

    property p_ext_rsvd;
        @(posedge clk_sys) disable iff (!rst_b)
        !legacyMode |-> (readValue[6:5] == 2'b00 && readValue[2] == 1'b0);
    endproperty
    a_ext_rsvd: assert property (p_ext_rsvd) else $error("Extended reserved bit reads one"); // R8

    property p_auto;
        @(posedge clk_sys) disable iff (!rst_b)
        (legacyMode && store_q[BIT_AUTO] && !cardIn) |=> !(supplyEn5 || supplyEn33);
    endproperty
    a_auto: assert property (p_auto) else $error("Supply on with empty socket"); // R3

    property p_supply_off;
        @(posedge clk_sys) disable iff (!rst_b)
        (legacyMode && !store_q[BIT_SUPPLY_EN]) |=> !socketPowerStatus;
    endproperty
    a_supply_off: assert property (p_supply_off) else $error("Supply on with enable clear"); // R4

    property p_vpp12;
        @(posedge clk_sys) disable iff (!rst_b)
        (supplyOn && vppField == VPP_12V) |=> vpp12En && !vppVccEn;
    endproperty
    a_vpp12: assert property (p_vpp12) else $error("Vpp 12 V request not honoured"); // R6

    property p_vpp_ignored;
        @(posedge clk_sys) disable iff (!rst_b)
        !supplyOn |=> !(vpp12En || vppVccEn);
    endproperty
    a_vpp_ignored: assert property (p_vpp_ignored) else $error("Vpp on without supply"); // R7 R10

    property p_vcc5;
        @(posedge clk_sys) disable iff (!rst_b)
        (!legacyMode && vccField == VCC_5V) |=> supplyEn5 && !supplyEn33;
    endproperty
    a_vcc5: assert property (p_vcc5) else $error("5 V request not honoured"); // R9

    property p_keep;
        @(posedge clk_sys) disable iff (!rst_b)
        (busReset && pmeEnable && !legacyMode) |=> (store_q == ($past(store_q) & KEEP_EXT));
    endproperty
    a_keep: assert property (p_keep) else $error("Bus reset cleared kept bits"); // R11

    property p_clear;
        @(posedge clk_sys) disable iff (!rst_b)
        (busReset && !pmeEnable) |=> (store_q == POWER_RESET);
    endproperty
    a_clear: assert property (p_clear) else $error("Bus reset left bits set"); // R11

    property p_status;
        @(posedge clk_sys) disable iff (!rst_b)
        socketPowerStatus == $past(supplyOn);
    endproperty
    a_status: assert property (p_status) else $error("Power status disagrees with supply"); // R14
endmodule // socket_power_reg
`default_nettype wire

// [rtl/socket_power_ctrl.sv]
// Top of the socket power control bank: register port, decode, revision field.
// Assumes pins arrive asynchronously; the system supply select comes from clk_sys logic.
`timescale 1ns/1ns
`default_nettype none
module socket_power_ctrl
    import socket_power_pkg::*;
#(
    parameter int NSOCK = 2 // Number of sockets
)
(
    input wire logic clk_sys, // System clock, 100 MHz
    input wire logic rst_b, // Global reset, async, low
    input wire logic busReset_b, // Bus reset pin, low
    input wire logic pmeEnable, // Power-event wake enable pin
    input wire logic [NSOCK-1:0] cardDetect1_b, // Card detect 1 pins, low
    input wire logic [NSOCK-1:0] cardDetect2_b, // Card detect 2 pins, low
    input wire logic systemSupplySelect, // Legacy supply level, 1 = 3.3 V
    input wire logic regIndexMode, // 1 = index space, 0 = socket-relative
    input wire logic [$clog2(NSOCK+1)-1:0] regSocket, // Socket for relative access
    input wire logic [11:0] regAddr, // Register offset
    input wire logic regWr, // Write strobe
    input wire logic regRd, // Read strobe
    input wire logic [7:0] regWrData, // Write data
    output logic [7:0] regRdData, // Read data, registered
    output logic regRdValid, // Read data valid pulse
    output logic legacyMode, // Legacy layout selected
    output logic [NSOCK-1:0] cardOutputsGate, // 16-bit outputs enabled
    output logic [NSOCK-1:0] autoPowerSwitchEnable, // Auto switching active
    output logic [NSOCK-1:0] supplyEn5, // Supply at 5 V
    output logic [NSOCK-1:0] supplyEn33, // Supply at 3.3 V
    output logic [NSOCK-1:0] vpp12En, // Vpp at 12 V
    output logic [NSOCK-1:0] vppVccEn, // Vpp tied to supply
    output logic [NSOCK-1:0] socketPowerStatus // Card supply on
);
    localparam int SW = 2 + 2 * NSOCK;

    // Refuse socket counts that the index stride and the socket select cannot serve
    if (NSOCK < 1 || NSOCK > 4)
    begin : g_bad_nsock
        $error("NSOCK must be 1 to 4");
    end

    logic [SW-1:0] sync1_q, sync2_q;
    logic busReset, pmeSync;
    logic [NSOCK-1:0] cardIn;
    logic [NSOCK-1:0] powerHit, revHit;
    logic [7:0] readVal [NSOCK];
    logic [3:0] rev_q, rev_d;
    logic [7:0] rdData_q, rdData_d;
    logic rdValid_q, rdValid_d;

    // Offset match for one socket in either address space
    function automatic logic addrHit(input logic idx, input logic [$clog2(NSOCK+1)-1:0] sock,
                                     input logic [11:0] addr, input int s,
                                     input logic [7:0] idxBase, input logic [11:0] relBase);
        logic [7:0] idxOfs;
        idxOfs = idxBase + SOCK_STRIDE * 8'(s);
        if (idx)
            return addr == {4'h0, idxOfs};
        else
            return (addr == relBase) && (sock == ($clog2(NSOCK+1))'(s));
    endfunction

    // Two-flop synchronisers for every pin input
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= {~busReset_b, pmeEnable, ~cardDetect2_b, ~cardDetect1_b};
            sync2_q <= sync1_q;
        end
    end

    // Card counts as seated only when both detects are asserted
    assign busReset = sync2_q[SW-1];
    assign pmeSync = sync2_q[SW-2];
    assign cardIn = sync2_q[NSOCK-1:0] & sync2_q[2*NSOCK-1:NSOCK];

    // Address decode per socket
    always_comb
    begin
        for (int s = 0; s < NSOCK; s++)
        begin
            powerHit[s] = addrHit(regIndexMode, regSocket, regAddr, s, OFS_POWER_IDX, OFS_POWER_REL); // R12
            revHit[s] = addrHit(regIndexMode, regSocket, regAddr, s, OFS_REV_IDX, OFS_REV_REL);
        end
    end

    // Revision field and read path; unmapped offsets read zero
    always_comb
    begin
        rev_d = rev_q;
        if (regWr && (|revHit))
        begin
            rev_d = regWrData[3:0]; // R13
        end
        rdValid_d = regRd;
        rdData_d = rdData_q;
        if (regRd)
        begin
            rdData_d = READ_NONE;
            for (int s = 0; s < NSOCK; s++)
            begin
                if (powerHit[s])
                    rdData_d = readVal[s];
                else if (revHit[s])
                    rdData_d = {4'h0, rev_q};
            end
        end
    end

    // The revision returns to 0100b only on the global reset, never on the bus reset
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rev_q <= REV_RESET; // R13
            rdData_q <= READ_NONE;
            rdValid_q <= 1'b0;
        end
        else
        begin
            rev_q <= rev_d;
            rdData_q <= rdData_d;
            rdValid_q <= rdValid_d;
        end
    end

    assign legacyMode = (rev_q == REV_LEGACY); // R13
    assign regRdData = rdData_q;
    assign regRdValid = rdValid_q;

    // One register copy per socket
    for (genvar s = 0; s < NSOCK; s++)
    begin : g_sock
        socket_power_reg u_reg (
            .clk_sys(clk_sys),
            .rst_b(rst_b),
            .wrEn(regWr && powerHit[s]), // R12
            .wrData(regWrData),
            .legacyMode(legacyMode),
            .busReset(busReset),
            .pmeEnable(pmeSync),
            .cardIn(cardIn[s]),
            .supplySelect(systemSupplySelect),
            .readValue(readVal[s]),
            .cardOutputsGate(cardOutputsGate[s]),
            .autoPowerSwitchEnable(autoPowerSwitchEnable[s]),
            .supplyEn5(supplyEn5[s]),
            .supplyEn33(supplyEn33[s]),
            .vpp12En(vpp12En[s]),
            .vppVccEn(vppVccEn[s]),
            .socketPowerStatus(socketPowerStatus[s])
        );
    end

    property p_rev_legacy;
        @(posedge clk_sys) disable iff (!rst_b)
        (regWr && (|revHit) && regWrData[3:0] == REV_LEGACY) |=> legacyMode;
    endproperty
    a_rev_legacy: assert property (p_rev_legacy) else $error("Legacy layout not entered"); // R13

    property p_rev_bus_reset;
        @(posedge clk_sys) disable iff (!rst_b)
        (busReset && !regWr) |=> (rev_q == $past(rev_q));
    endproperty
    a_rev_bus_reset: assert property (p_rev_bus_reset) else $error("Revision changed by bus reset"); // R13

    property p_read_sock;
        @(posedge clk_sys) disable iff (!rst_b)
        (regRd && powerHit[0]) |=> regRdValid && (regRdData == $past(readVal[0]));
    endproperty
    a_read_sock: assert property (p_read_sock) else $error("Socket register read wrong"); // R12
endmodule // socket_power_ctrl
`default_nettype wire

// [dv/socket_card_model.sv]
// Behavioural socket: card detect pins and the supply the power switch delivers.
// Assumes the controller's supply enables arrive as plain per-socket levels.
`timescale 1ns/1ns
`default_nettype none
module socket_card_model
#(
    parameter int NSOCK = 2 // Number of sockets
)
(
    input wire logic [NSOCK-1:0] cardInserted, // Card seated per socket
    input wire logic [NSOCK-1:0] supplyEn5, // Switch request 5 V
    input wire logic [NSOCK-1:0] supplyEn33, // Switch request 3.3 V
    output logic [NSOCK-1:0] cardDetect1_b, // Detect pin 1, pulled up
    output logic [NSOCK-1:0] cardDetect2_b, // Detect pin 2, pulled up
    output logic [NSOCK-1:0] cardPowered // Supply reaches the card
);
    // Empty socket leaves both detect pins at their pull-up level
    assign cardDetect1_b = ~cardInserted;
    assign cardDetect2_b = ~cardInserted;
    // Both rails requested at once would short the switch, so that never counts as power
    assign cardPowered = cardInserted & (supplyEn5 ^ supplyEn33);
endmodule // socket_card_model
`default_nettype wire

// [dv/socket_power_control_register_bench.sv]
// Self-checking bench for the socket power control register bank.
// Assumes the register port contract of socket_power_ctrl and the socket model.
`timescale 1ns/1ns
`default_nettype none
module socket_power_control_register_bench;
    import socket_power_pkg::*;
    logic clk_sys = 1'h0;
    logic rst_b = 1'h0;
    logic busReset_b = 1'h1;
    logic pmeEnable = 1'h0;
    logic systemSupplySelect = 1'h0;
    logic regIndexMode = 1'h1;
    logic [1:0] regSocket = 2'h0;
    logic [11:0] regAddr = 12'h000;
    logic regWr = 1'h0;
    logic regRd = 1'h0;
    logic [7:0] regWrData = 8'h00;
    logic [1:0] cardInserted = 2'h0;
    logic [1:0] cd1B, cd2B, cardPowered, gate, autoSw, en5, en33, v12, vVcc, pwrStat;
    logic [7:0] regRdData;
    logic regRdValid, legacyMode;
    int bad_count = 0;
    int comparisons = 0;

    // Free-running 100 MHz clock
    always #5 clk_sys = ~clk_sys;

    socket_power_ctrl #(.NSOCK(2)) u_socket_power_ctrl (.clk_sys(clk_sys), .rst_b(rst_b),
        .busReset_b(busReset_b), .pmeEnable(pmeEnable), .cardDetect1_b(cd1B), .cardDetect2_b(cd2B),
        .systemSupplySelect(systemSupplySelect), .regIndexMode(regIndexMode), .regSocket(regSocket),
        .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .legacyMode(legacyMode), .cardOutputsGate(gate),
        .autoPowerSwitchEnable(autoSw), .supplyEn5(en5), .supplyEn33(en33), .vpp12En(v12),
        .vppVccEn(vVcc), .socketPowerStatus(pwrStat));

    socket_card_model #(.NSOCK(2)) u_socket_card_model (.cardInserted(cardInserted),
        .supplyEn5(en5), .supplyEn33(en33), .cardDetect1_b(cd1B), .cardDetect2_b(cd2B),
        .cardPowered(cardPowered));

    // Verdict in one place for the main sequence and the watchdog
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Write, then let the register and the output flop both land
    task automatic wr(input logic idx, input logic [1:0] sk, input logic [11:0] a, input logic [7:0] d);
        regIndexMode = idx;
        regSocket = sk;
        regAddr = a;
        regWrData = d;
        regWr = 1'h1;
        @(posedge clk_sys);
        #1 regWr = 1'h0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    // Read data and its valid pulse are looked at in the cycle after the strobe
    task automatic rd(input logic idx, input logic [1:0] sk, input logic [11:0] a, input logic [7:0] exp);
        regIndexMode = idx;
        regSocket = sk;
        regAddr = a;
        regRd = 1'h1;
        @(posedge clk_sys);
        #1 regRd = 1'h0;
        chk8("read valid", 8'h01, {7'h0, regRdValid});
        chk8("read data", exp, regRdData);
        // Idle edge so a following read never re-raises the strobe in this time step
        @(posedge clk_sys);
        #1;
    endtask

    // Order: gate, auto, 5 V, 3.3 V, Vpp 12 V, Vpp at supply
    task automatic outs(input int s, input logic [5:0] exp);
        chk8("socket outputs", {2'h0, exp}, {2'h0, gate[s], autoSw[s], en5[s], en33[s], v12[s], vVcc[s]});
    endtask

    // Lead-in lets the wake enable through its synchroniser before the pulse
    task automatic busRst();
        repeat (3) @(posedge clk_sys);
        #1 busReset_b = 1'h0;
        repeat (5) @(posedge clk_sys);
        #1 busReset_b = 1'h1;
        repeat (5) @(posedge clk_sys);
        #1;
    endtask

    initial
    begin : mainSeq
        logic [7:0] d;
        logic on;
        repeat (10) @(posedge clk_sys);
        #1 rst_b = 1'h1;
        // Reset values, then an unmapped offset
        rd(1'h1, 2'h0, 12'h002, POWER_RESET);
        rd(1'h1, 2'h0, 12'h042, POWER_RESET);
        rd(1'h1, 2'h0, 12'h000, {4'h0, REV_RESET});
        chk8("legacy mode", 8'h00, {7'h0, legacyMode});
        rd(1'h1, 2'h0, 12'h005, READ_NONE);
        wr(1'h1, 2'h0, 12'h002, 8'hff);
        rd(1'h1, 2'h0, 12'h002, 8'h9b);
        // Every supply and Vpp code pair in the extended layout
        for (int c = 0; c < 4; c++)
            for (int p = 0; p < 4; p++)
            begin
                d = {1'h1, 2'h0, c[1:0], 1'h0, p[1:0]};
                wr(1'h1, 2'h0, 12'h002, d);
                rd(1'h1, 2'h0, 12'h002, d);
                on = (c >= 2);
                outs(0, {1'h1, 1'h0, c == 2, c == 3, on && p == 2, on && p == 1});
                if (!on || p inside {1, 2})
                    chk8("power status", {7'h0, on}, {7'h0, pwrStat[0]});
            end
        // Second copy through socket-relative space
        pmeEnable = 1'h1;
        wr(1'h0, 2'h1, 12'h802, 8'h80);
        rd(1'h1, 2'h0, 12'h042, 8'h80);
        rd(1'h0, 2'h0, 12'h802, 8'h9b);
        outs(1, 6'h20);
        busRst();
        rd(1'h1, 2'h0, 12'h042, 8'h80);
        pmeEnable = 1'h0;
        busRst();
        rd(1'h1, 2'h0, 12'h002, POWER_RESET);
        // Legacy layout
        wr(1'h1, 2'h0, 12'h000, {4'h0, REV_LEGACY});
        chk8("legacy mode", 8'h01, {7'h0, legacyMode});
        wr(1'h1, 2'h0, 12'h002, 8'hff);
        rd(1'h1, 2'h0, 12'h002, 8'hb3);
        outs(0, 6'h30);
        systemSupplySelect = 1'h1;
        cardInserted = 2'h1;
        repeat (5) @(posedge clk_sys);
        #1;
        outs(0, 6'h34);
        chk8("card powered", 8'h01, {7'h0, cardPowered[0]});
        systemSupplySelect = 1'h0;
        wr(1'h1, 2'h0, 12'h002, 8'h11);
        outs(0, 6'h09);
        chk8("power status", 8'h01, {7'h0, pwrStat[0]});
        wr(1'h1, 2'h0, 12'h002, 8'h02);
        outs(0, 6'h00);
        chk8("power status", 8'h00, {7'h0, pwrStat[0]});
        wr(1'h1, 2'h0, 12'h002, 8'h12);
        outs(0, 6'h0a);
        wr(1'h1, 2'h0, 12'h002, 8'hb2);
        pmeEnable = 1'h1;
        busRst();
        rd(1'h1, 2'h0, 12'h002, 8'h20);
        chk8("legacy mode", 8'h01, {7'h0, legacyMode});
        pmeEnable = 1'h0;
        busRst();
        rd(1'h1, 2'h0, 12'h002, POWER_RESET);
        // Global reset mid-run beats the wake-kept bits
        pmeEnable = 1'h1;
        wr(1'h1, 2'h0, 12'h002, 8'h20);
        rst_b = 1'h0;
        repeat (3) @(posedge clk_sys);
        #1 rst_b = 1'h1;
        rd(1'h1, 2'h0, 12'h002, POWER_RESET);
        rd(1'h1, 2'h0, 12'h000, {4'h0, REV_RESET});
        final_report();
    end

    // Whole run is about 200 cycles; this cuts a hang short
    initial
    begin
        #200000;
        bad_count++;
        $display("[ERR] run end expected done seen hang");
        final_report();
    end
endmodule // socket_power_control_register_bench
`default_nettype wire
